// ==== shared/cpph_pkg.sv ====
// Package for the phase-driven core: widths, phase encoding, opcode classes, pin modes.
// Assumes a single 50 MHz clock domain and no register bus.
package cpph_pkg;
    localparam int CPPH_IW = 14;
    localparam int CPPH_DW = 8;
    localparam int CPPH_PCW = 13;
    localparam int CPPH_AW = 7;
    localparam logic [12:0] CPPH_PC_RESET = 13'h0000;
    localparam logic [7:0] CPPH_W_RESET = 8'h00;
    localparam logic [13:0] CPPH_NOP = 14'h0000;
    localparam logic [6:0] CPPH_PCL_ADDR = 7'h02;
    localparam logic [6:0] CPPH_STATUS_ADDR = 7'h03;
    localparam logic [6:0] CPPH_FSR_ADDR = 7'h04;
    localparam logic [6:0] CPPH_INDF_ADDR = 7'h00;
    localparam int CPPH_C_BIT = 0;
    localparam int CPPH_DC_BIT = 1;
    localparam int CPPH_Z_BIT = 2;
    localparam logic [2:0] CPPH_FLAGS_RESET = 3'h0;
    localparam logic [1:0] CPPH_PH_ONE = 2'h0;
    localparam logic [1:0] CPPH_PH_TWO = 2'h1;
    localparam logic [1:0] CPPH_PH_THREE = 2'h2;
    localparam logic [1:0] CPPH_PH_FOUR = 2'h3;
    // Oscillator modes.
    typedef enum logic [2:0] {
        CPPH_LOW_POWER_CRYSTAL_MODE, CPPH_STANDARD_CRYSTAL_MODE, CPPH_FAST_CRYSTAL_MODE,
        CPPH_INTERNAL_RC_MODE, CPPH_EXTERNAL_RC_MODE
    } cpph_osc_type;
    // ALU operations decoded from the instruction.
    typedef enum logic [3:0] {
        CPPH_OP_NOP, CPPH_OP_ADD, CPPH_OP_SUB, CPPH_OP_AND, CPPH_OP_IOR, CPPH_OP_XOR,
        CPPH_OP_MOVW, CPPH_OP_MOVF, CPPH_OP_CLR, CPPH_OP_COM, CPPH_OP_INC, CPPH_OP_DEC,
        CPPH_OP_RLF, CPPH_OP_RRF, CPPH_OP_GOTO
    } cpph_op_type;
endpackage

// ==== rtl/cpph_phase_gen.sv ====
// Four-phase generator: counts input clocks and emits one-cycle phase enables.
// Assumes clk_in is the oscillator clock; reset restarts at the first phase.
`timescale 1ns/1ps
`default_nettype none
module cpph_phase_gen (
    input wire logic clk_in,
    input wire logic rst_n_in,
    output logic [1:0] phase_out,
    output logic phase_one_out,
    output logic phase_two_out,
    output logic phase_four_out,
    output logic quarter_rate_clock_out
);
    import cpph_pkg::*;
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    logic qclk_r;
    logic qclk_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Divide by four; the quarter clock is high in phases one and two.
    always_comb begin
        phase_nxt = phase_r + 2'h1; // [RULE_01]
        qclk_nxt = (phase_nxt == CPPH_PH_ONE) || (phase_nxt == CPPH_PH_TWO);
    end

    // Register the phase; reset returns to phase one.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_r <= CPPH_PH_ONE; // [RULE_24]
            qclk_r <= 1'b1;
        end else begin
            phase_r <= phase_nxt;
            qclk_r <= qclk_nxt;
        end
    end

    // Phase enables are decoded from the registered count.
    assign phase_out = phase_r;
    assign phase_one_out = (phase_r == CPPH_PH_ONE);
    assign phase_two_out = (phase_r == CPPH_PH_TWO);
    assign phase_four_out = (phase_r == CPPH_PH_FOUR);
    assign quarter_rate_clock_out = qclk_r;
endmodule
`default_nettype wire

// ==== rtl/cpph_core.sv ====
// Core pipeline: phase-sequenced fetch/execute, ALU, working register, flags, pin functions.
// Assumes program memory answers combinationally within a phase, data memory likewise.
// Functional notes
// RULE_01: Input clock divided by four into four ordered non-overlapping phases.
// RULE_02: Program counter increments once per instruction cycle in phase one.
// RULE_03: Fetched word captured into instruction register in phase four.
// RULE_04: Captured instruction executes over the four phases of the next cycle.
// RULE_05: Two-stage pipeline overlaps next fetch with current execution.
// RULE_06: All operations take one cycle except branches.
// RULE_07: Each instruction is one 14-bit word fetched in one cycle.
// RULE_08: Program and data memory use separate buses; data is 8 bits.
// RULE_09: 8-bit ALU does add, subtract, shift, logic in two's complement.
// RULE_10: Two-operand ops use accumulator plus file or literal; single-operand either.
// RULE_11: Accumulator is 8 bits and not at any data address.
// RULE_12: ALU updates carry, half-carry and zero flags per instruction.
// RULE_13: In subtraction carry is borrow-not and half-carry digit borrow-not.
// RULE_14: Special registers including program counter reachable directly and indirectly.
// RULE_15: In RC modes the output pin may drive a quarter-rate clock.
// RULE_16: Pin four is crystal output only in crystal modes, else I/O.
// RULE_17: Pin five is I/O only in internal RC mode, else clock input.
// RULE_18: With external reset enabled, low on pin three resets the device.
// RULE_19: With external reset enabled, pin three pull-up is forced on.
// RULE_20: Pins zero, one, three have selectable pull-ups and change interrupts.
// RULE_21: Pin two may be timer clock or external interrupt input.
// RULE_22: Program counter changes cost two cycles by flushing the fetched word.
// RULE_23: Operand read in phase two, destination written in phase four.
// RULE_24: Reset restarts phases at one with no valid instruction.
`timescale 1ns/1ps
`default_nettype none
module cpph_core (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire cpph_pkg::cpph_osc_type osc_mode_in,
    input wire logic ext_reset_enable_in,
    input wire logic quarter_rate_clock_out_enable_in,
    input wire logic [3:0] pullup_select_in,
    input wire logic [3:0] change_irq_select_in,
    input wire logic port_pin_two_timer_in,
    input wire logic port_pin_two_irq_in,
    input wire logic [5:0] port_pins_in,
    input wire logic [13:0] prog_data_in,
    input wire logic [7:0] data_rd_in,
    output logic [12:0] prog_addr_out,
    output logic [6:0] data_addr_out,
    output logic data_rd_en_out,
    output logic [7:0] data_wr_out,
    output logic data_wr_en_out,
    output logic [7:0] w_out,
    output logic [2:0] flags_out,
    output logic [1:0] phase_out,
    output logic exec_valid_out,
    output logic quarter_rate_clock_out,
    output logic port_pin_four_quarter_rate_clock_out_en_out,
    output logic port_pin_four_is_crystal_out,
    output logic port_pin_five_is_clock_in_out,
    output logic [3:0] pullup_active_out,
    output logic [3:0] change_irq_active_out,
    output logic timer_clock_input_out,
    output logic external_irq_input_out,
    output logic [5:0] port_change_out
);
    import cpph_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset: external reset pin low combines with the power-on reset when enabled.
    logic core_rst_n;
    assign core_rst_n = rst_n_in & ~(ext_reset_enable_in & ~port_pins_in[3]); // [RULE_18]

    logic [1:0] phase;
    logic phase_one;
    logic phase_two;
    logic phase_four;
    logic qclk;

    // Phase generator drives all sequencing below.
    cpph_phase_gen u_phase (
        .clk_in(clk_in),
        .rst_n_in(core_rst_n),
        .phase_out(phase),
        .phase_one_out(phase_one),
        .phase_two_out(phase_two),
        .phase_four_out(phase_four),
        .quarter_rate_clock_out(qclk)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helper: classifies a 14-bit word into an ALU operation.
    function automatic cpph_op_type decode_op(input logic [13:0] ir);
        cpph_op_type op;
        op = CPPH_OP_NOP;
        if (ir[13:11] == 3'b101) begin
            op = CPPH_OP_GOTO;
        end else if (ir[13:12] == 2'b00) begin
            unique case (ir[11:8])
                4'h0: op = ir[7] ? CPPH_OP_MOVW : CPPH_OP_NOP;
                4'h1: op = CPPH_OP_CLR;
                4'h2: op = CPPH_OP_SUB;
                4'h3: op = CPPH_OP_DEC;
                4'h4: op = CPPH_OP_IOR;
                4'h5: op = CPPH_OP_AND;
                4'h6: op = CPPH_OP_XOR;
                4'h7: op = CPPH_OP_ADD;
                4'h8: op = CPPH_OP_MOVF;
                4'h9: op = CPPH_OP_COM;
                4'hA: op = CPPH_OP_INC;
                4'hC: op = CPPH_OP_RRF;
                4'hD: op = CPPH_OP_RLF;
                default: op = CPPH_OP_NOP;
            endcase
        end else if (ir[13:12] == 2'b11) begin
            unique case (ir[11:9])
                3'b111: op = CPPH_OP_ADD;
                3'b110: op = CPPH_OP_SUB;
                3'b101: op = CPPH_OP_XOR;
                3'b100: op = ir[8] ? CPPH_OP_AND : CPPH_OP_IOR;
                3'b000: op = CPPH_OP_MOVW;
                default: op = CPPH_OP_MOVW;
            endcase
        end
        return op;
    endfunction

    // True when the word takes a literal rather than a file operand.
    function automatic logic is_literal(input logic [13:0] ir);
        return ir[13:12] == 2'b11;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pipeline state.
    logic [12:0] pc_r, pc_nxt;
    logic [13:0] fetch_r, fetch_nxt;
    logic [13:0] ir_r, ir_nxt;
    logic ir_valid_r, ir_valid_nxt;
    logic fetch_valid_r, fetch_valid_nxt;
    logic [7:0] w_r, w_nxt;
    logic [2:0] flags_r, flags_nxt;
    logic [7:0] fsr_r, fsr_nxt;
    logic [7:0] operand_r, operand_nxt;
    logic [5:0] pins_prev_r, pins_prev_nxt;
    logic [5:0] change_r, change_nxt;

    // ALU working signals.
    cpph_op_type op;
    logic [7:0] opnd;
    logic [7:0] result;
    logic [8:0] sum;
    logic [4:0] nib;
    logic dest_file;
    logic write_w;
    logic write_f;
    logic set_c, set_dc, set_z;
    logic [6:0] faddr;
    logic [7:0] pcl_view;

    ////////////////////////////////////////////////////////////////////////////////
    // Data address: indirect through the file pointer when the address is zero.
    always_comb begin
        faddr = ir_r[6:0];
        if (faddr == CPPH_INDF_ADDR) begin
            faddr = fsr_r[6:0]; // [RULE_14]
        end
        op = decode_op(ir_r);
        opnd = is_literal(ir_r) ? ir_r[7:0] : operand_r; // [RULE_10]
        dest_file = ir_r[7] & ~is_literal(ir_r);
        pcl_view = pc_r[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ALU: 8-bit, two's complement, with carry, half-carry and zero.
    always_comb begin
        result = opnd;
        sum = 9'h000;
        nib = 5'h00;
        set_c = 1'b0;
        set_dc = 1'b0;
        set_z = 1'b0;
        write_w = 1'b0;
        write_f = 1'b0;
        unique case (op)
            CPPH_OP_ADD: begin
                sum = {1'b0, opnd} + {1'b0, w_r}; // [RULE_09]
                nib = {1'b0, opnd[3:0]} + {1'b0, w_r[3:0]};
                result = sum[7:0];
                set_c = 1'b1;
                set_dc = 1'b1;
                set_z = 1'b1;
            end
            CPPH_OP_SUB: begin
                // Carry high means no borrow; likewise for the low nibble.
                sum = {1'b0, opnd} + {1'b0, ~w_r} + 9'h001; // [RULE_13]
                nib = {1'b0, opnd[3:0]} + {1'b0, ~w_r[3:0]} + 5'h01;
                result = sum[7:0];
                set_c = 1'b1;
                set_dc = 1'b1;
                set_z = 1'b1;
            end
            CPPH_OP_AND: begin
                result = opnd & w_r;
                set_z = 1'b1;
            end
            CPPH_OP_IOR: begin
                result = opnd | w_r;
                set_z = 1'b1;
            end
            CPPH_OP_XOR: begin
                result = opnd ^ w_r;
                set_z = 1'b1;
            end
            CPPH_OP_MOVW: begin
                result = is_literal(ir_r) ? opnd : w_r;
            end
            CPPH_OP_MOVF: begin
                result = opnd;
                set_z = 1'b1;
            end
            CPPH_OP_CLR: begin
                result = 8'h00;
                set_z = 1'b1;
            end
            CPPH_OP_COM: begin
                result = ~opnd;
                set_z = 1'b1;
            end
            CPPH_OP_INC: begin
                result = opnd + 8'h01;
                set_z = 1'b1;
            end
            CPPH_OP_DEC: begin
                result = opnd - 8'h01;
                set_z = 1'b1;
            end
            CPPH_OP_RLF: begin
                result = {opnd[6:0], flags_r[CPPH_C_BIT]};
                sum = {opnd[7], 8'h00};
                set_c = 1'b1;
            end
            CPPH_OP_RRF: begin
                result = {flags_r[CPPH_C_BIT], opnd[7:1]};
                sum = {opnd[0], 8'h00};
                set_c = 1'b1;
            end
            CPPH_OP_GOTO, CPPH_OP_NOP: begin
                result = opnd;
            end
        endcase
        if (op != CPPH_OP_NOP && op != CPPH_OP_GOTO) begin
            // Literal ops and clear-W go to W; file ops follow the destination bit.
            write_f = dest_file || (op == CPPH_OP_MOVW && !is_literal(ir_r));
            write_w = !write_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing of fetch, execute, operand read and writeback per phase.
    always_comb begin
        pc_nxt = pc_r;
        fetch_nxt = fetch_r;
        ir_nxt = ir_r;
        ir_valid_nxt = ir_valid_r;
        fetch_valid_nxt = fetch_valid_r;
        w_nxt = w_r;
        flags_nxt = flags_r;
        fsr_nxt = fsr_r;
        operand_nxt = operand_r;
        if (phase_one) begin
            // Hand the fetched word on; step past it only once it was really fetched.
            pc_nxt = fetch_valid_r ? pc_r + 13'h0001 : pc_r; // [RULE_02]
            ir_nxt = fetch_r; // [RULE_04] [RULE_05]
            ir_valid_nxt = fetch_valid_r;
        end
        if (phase_two && ir_valid_r) begin
            operand_nxt = (faddr == CPPH_PCL_ADDR) ? pcl_view :
                          (faddr == CPPH_STATUS_ADDR) ? {5'h00, flags_r} :
                          (faddr == CPPH_FSR_ADDR) ? fsr_r : data_rd_in; // [RULE_23] [RULE_14]
        end
        if (phase_four) begin
            fetch_nxt = prog_data_in; // [RULE_03] [RULE_07]
            fetch_valid_nxt = 1'b1;
            if (ir_valid_r) begin
                if (write_w) begin
                    w_nxt = result; // [RULE_11]
                end
                if (set_c) begin
                    flags_nxt[CPPH_C_BIT] = sum[8]; // [RULE_12]
                end
                if (set_dc) begin
                    flags_nxt[CPPH_DC_BIT] = nib[4];
                end
                if (set_z) begin
                    flags_nxt[CPPH_Z_BIT] = (result == 8'h00);
                end
                if (write_f && faddr == CPPH_STATUS_ADDR) begin
                    flags_nxt = result[2:0];
                end
                if (write_f && faddr == CPPH_FSR_ADDR) begin
                    fsr_nxt = result;
                end
                if (op == CPPH_OP_GOTO) begin
                    // Redirect and flush the word already fetched.
                    pc_nxt = {2'b00, ir_r[10:0]}; // [RULE_22] [RULE_06]
                    fetch_valid_nxt = 1'b0;
                end else if (write_f && faddr == CPPH_PCL_ADDR) begin
                    pc_nxt = {pc_r[12:8], result}; // [RULE_22]
                    fetch_valid_nxt = 1'b0;
                end
            end
        end
    end

    // Pipeline registers; reset leaves no valid instruction.
    always_ff @(posedge clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            pc_r <= CPPH_PC_RESET;
            fetch_r <= CPPH_NOP;
            ir_r <= CPPH_NOP;
            ir_valid_r <= 1'b0; // [RULE_24]
            fetch_valid_r <= 1'b0;
            w_r <= CPPH_W_RESET;
            flags_r <= CPPH_FLAGS_RESET;
            fsr_r <= 8'h00;
            operand_r <= 8'h00;
        end else begin
            pc_r <= pc_nxt;
            fetch_r <= fetch_nxt;
            ir_r <= ir_nxt;
            ir_valid_r <= ir_valid_nxt;
            fetch_valid_r <= fetch_valid_nxt;
            w_r <= w_nxt;
            flags_r <= flags_nxt;
            fsr_r <= fsr_nxt;
            operand_r <= operand_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin change detection on the selected pins.
    always_comb begin
        pins_prev_nxt = port_pins_in;
        change_nxt = 6'h00;
        for (int i = 0; i < 4; i++) begin
            if (change_irq_active_out[i]) begin
                change_nxt[i] = port_pins_in[i] ^ pins_prev_r[i]; // [RULE_20]
            end
        end
    end

    // Register the pin history.
    always_ff @(posedge clk_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            pins_prev_r <= 6'h00;
            change_r <= 6'h00;
        end else begin
            pins_prev_r <= pins_prev_nxt;
            change_r <= change_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and status outputs; separate program and data buses.
    assign prog_addr_out = pc_r; // [RULE_08]
    assign data_addr_out = faddr;
    assign data_rd_en_out = phase_two & ir_valid_r;
    assign data_wr_out = result;
    assign data_wr_en_out = phase_four & ir_valid_r & write_f; // [RULE_23]
    assign w_out = w_r;
    assign flags_out = flags_r;
    assign phase_out = phase;
    assign exec_valid_out = ir_valid_r;

    // Pin function selection by oscillator mode and option inputs.
    assign port_pin_four_is_crystal_out = (osc_mode_in == CPPH_FAST_CRYSTAL_MODE) ||
        (osc_mode_in == CPPH_STANDARD_CRYSTAL_MODE) ||
        (osc_mode_in == CPPH_LOW_POWER_CRYSTAL_MODE); // [RULE_16]
    assign port_pin_four_quarter_rate_clock_out_en_out = quarter_rate_clock_out_enable_in &&
        ((osc_mode_in == CPPH_EXTERNAL_RC_MODE) || (osc_mode_in == CPPH_INTERNAL_RC_MODE)); // [RULE_15]
    assign quarter_rate_clock_out = port_pin_four_quarter_rate_clock_out_en_out & qclk; // [RULE_15]
    assign port_pin_five_is_clock_in_out = (osc_mode_in != CPPH_INTERNAL_RC_MODE); // [RULE_17]
    assign pullup_active_out = {pullup_select_in[3] | ext_reset_enable_in, 1'b0,
        pullup_select_in[1:0]}; // [RULE_19] [RULE_20]
    assign change_irq_active_out = {change_irq_select_in[3], 1'b0, change_irq_select_in[1:0]};
    assign timer_clock_input_out = port_pin_two_timer_in & port_pins_in[2]; // [RULE_21]
    assign external_irq_input_out = port_pin_two_irq_in & port_pins_in[2]; // [RULE_21]
    assign port_change_out = change_r;
endmodule
`default_nettype wire

// ==== verif/cpph_core_monitor.sv ====
// Checker for the phase core: phase order, data slots and pin functions.
// Bound into cpph_core; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cpph_core_monitor (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire cpph_pkg::cpph_osc_type osc_mode_in,
    input wire logic ext_reset_enable_in,
    input wire logic [5:0] port_pins_in,
    input wire logic data_rd_en_out,
    input wire logic data_wr_en_out,
    input wire logic [7:0] w_out,
    input wire logic [1:0] phase_out,
    input wire logic exec_valid_out,
    input wire logic quarter_rate_clock_out,
    input wire logic port_pin_four_is_crystal_out,
    input wire logic port_pin_five_is_clock_in_out,
    input wire logic [3:0] pullup_active_out
);
    import cpph_pkg::*;
    // Either reset source holds the core.
    wire logic dev_rst = !rst_n_in || (ext_reset_enable_in && !port_pins_in[3]);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (dev_rst);
    ////////////////////////////////////////////////////////////////////////////
    // Phase order and data slots.
    phase_seq_a: assert property (!$past(dev_rst) |-> phase_out == 2'($past(phase_out) + 2'h1))
        else $error("phase did not step by one");
    rd_slot_a: assert property (data_rd_en_out |-> exec_valid_out && phase_out == CPPH_PH_TWO)
        else $error("operand read outside phase two");
    wr_slot_a: assert property (data_wr_en_out |-> exec_valid_out && phase_out == CPPH_PH_FOUR)
        else $error("destination write outside phase four");
    w_update_a: assert property ($changed(w_out) |->
        $past(phase_out) == CPPH_PH_FOUR && $past(exec_valid_out))
        else $error("accumulator changed outside execution");
    ////////////////////////////////////////////////////////////////////////////
    // Pin functions.
    quarter_rate_clock_out_period_a: assert property ($fell(quarter_rate_clock_out) |=>
        !quarter_rate_clock_out ##1 quarter_rate_clock_out)
        else $error("quarter rate clock has wrong period");
    pullup_force_a: assert property (ext_reset_enable_in |-> pullup_active_out[3])
        else $error("reset pin pull-up not forced");
    crystal_pin_a: assert property (port_pin_four_is_crystal_out == (osc_mode_in < CPPH_INTERNAL_RC_MODE))
        else $error("pin four crystal use wrong");
    clock_pin_a: assert property (port_pin_five_is_clock_in_out == (osc_mode_in != CPPH_INTERNAL_RC_MODE))
        else $error("pin five clock use wrong");
endmodule
bind cpph_core cpph_core_monitor u_mon (.*);
`default_nettype wire

// ==== verif/cpph_mem_model.sv ====
// Memory model: program words and data bytes on separate buses.
// Assumes the bench loads rom before reset is released.
`timescale 1ns/1ps
`default_nettype none
module cpph_mem_model (
    input wire logic clk_in,
    input wire logic [12:0] prog_addr_in,
    input wire logic [6:0] data_addr_in,
    input wire logic data_rd_en_in,
    input wire logic [7:0] data_wr_in,
    input wire logic data_wr_en_in,
    output logic [13:0] prog_data_out,
    output logic [7:0] data_rd_out
);
    logic [13:0] rom [16];
    logic [7:0] ram [128];
    logic [7:0] noise_r = 8'h5A;
    // Words past the table read as a no-op.
    assign prog_data_out = (prog_addr_in < 13'h0010) ? rom[prog_addr_in[3:0]] : 14'h0000;
    // An idle data bus shows moving noise.
    assign data_rd_out = data_rd_en_in ? ram[data_addr_in] : noise_r;
    // Byte writes land at the slot's last edge.
    always @(posedge clk_in) begin
        noise_r <= noise_r + 8'h3B;
        if (data_wr_en_in) begin
            ram[data_addr_in] <= data_wr_in;
        end
    end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the phase core.
// Assumes a memory model that answers at once.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cpph_pkg::*;
    logic clk_in, rst_n_in, ext_reset_enable_in, quarter_rate_clock_out_enable_in, port_pin_two_timer_in, port_pin_two_irq_in;
    logic data_rd_en_out, data_wr_en_out, exec_valid_out, quarter_rate_clock_out, port_pin_four_quarter_rate_clock_out_en_out;
    logic port_pin_four_is_crystal_out, port_pin_five_is_clock_in_out, timer_clock_input_out, external_irq_input_out;
    cpph_osc_type osc_mode_in;
    logic [3:0] pullup_select_in, change_irq_select_in, pullup_active_out, change_irq_active_out;
    logic [5:0] port_pins_in, port_change_out;
    logic [13:0] prog_data_in;
    logic [12:0] prog_addr_out;
    logic [7:0] data_rd_in, data_wr_out, w_out;
    logic [6:0] data_addr_out;
    logic [2:0] flags_out;
    logic [1:0] phase_out;
    int err_count = 0, compares = 0, cyc = 0, prev = 0, gap = 0;
    // Core under test and its two memories.
    cpph_core dut (.*);
    cpph_mem_model mem (.clk_in, .prog_addr_in(prog_addr_out), .data_addr_in(data_addr_out),
        .data_rd_en_in(data_rd_en_out), .data_wr_in(data_wr_out), .data_wr_en_in(data_wr_en_out),
        .prog_data_out(prog_data_in), .data_rd_out(data_rd_in));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and a cycle count.
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc <= cyc + 1;
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string name, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic results();
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Waits for a valid write slot, then checks it.
    task automatic step(input logic [7:0] ew, input logic [2:0] ef);
        int n;
        n = 0;
        while (!(phase_out === CPPH_PH_FOUR && exec_valid_out === 1'b1) && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        chk("wait", n < 40, 1'b1);
        gap = cyc - prev;
        prev = cyc;
        @(negedge clk_in);
        chk("w", w_out, ew);
        chk("flags", flags_out, ef);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Reset state; nothing valid before the first fetch.
    task automatic t_start();
        chk("phase", phase_out, CPPH_PH_ONE);
        chk("pc", prog_addr_out, CPPH_PC_RESET);
        chk("w", w_out, CPPH_W_RESET);
        chk("flags", flags_out, CPPH_FLAGS_RESET);
        repeat (3) begin
            @(negedge clk_in);
            chk("valid", exec_valid_out, 1'b0);
        end
    endtask
    // Program run; the branch drops its shadow word.
    task automatic t_prog();
        logic [7:0] ew [10] = '{8'h0F, 8'h10, 8'h10, 8'h00, 8'hFF, 8'h01, 8'h10, 8'h10, 8'hFF, 8'h0F};
        logic [2:0] ef [10] = '{3'h0, 3'h2, 3'h2, 3'h7, 3'h7, 3'h3, 3'h3, 3'h3, 3'h2, 3'h2};
        for (int i = 0; i < 10; i++) begin
            step(ew[i], ef[i]);
            if (i > 0) chk("gap", gap, (i == 8) ? 8 : 4);
        end
        chk("ram", mem.ram[32], 8'h10);
    endtask
    // Pin functions by mode and option.
    task automatic t_pins();
        int hi;
        quarter_rate_clock_out_enable_in = 1'b1;
        for (int m = 0; m < 5; m++) begin
            osc_mode_in = cpph_osc_type'(m);
            hi = 0;
            @(negedge clk_in);
            repeat (8) begin
                @(negedge clk_in);
                hi += quarter_rate_clock_out;
            end
            chk("xtal", port_pin_four_is_crystal_out, m < 3);
            chk("clkin", port_pin_five_is_clock_in_out, m != 3);
            chk("quarter_rate_clock_out", hi, (m > 2) ? 4 : 0);
        end
        pullup_select_in = 4'hB;
        change_irq_select_in = 4'hB;
        port_pin_two_timer_in = 1'b1;
        port_pins_in = 6'h0C;
        repeat (4) @(negedge clk_in);
        chk("pullup", pullup_active_out, 4'hB);
        chk("chgirq", change_irq_active_out, 4'hB);
        chk("timer", timer_clock_input_out, 1'b1);
        chk("extirq", external_irq_input_out, 1'b0);
        hi = 0;
        port_pins_in[0] = 1'b1;
        repeat (6) begin
            @(negedge clk_in);
            hi += port_change_out[0];
        end
        chk("change", hi, 1);
        port_pin_two_timer_in = 1'b0;
        port_pin_two_irq_in = 1'b1;
        pullup_select_in = 4'h0;
        ext_reset_enable_in = 1'b1;
        @(negedge clk_in);
        chk("timer", timer_clock_input_out, 1'b0);
        chk("extirq", external_irq_input_out, 1'b1);
        chk("pullup", pullup_active_out, 4'h8);
    endtask
    // A low reset pin clears the core.
    task automatic t_xreset();
        port_pins_in[3] = 1'b0;
        @(negedge clk_in);
        quarter_rate_clock_out_enable_in = 1'b0;
        repeat (2) @(negedge clk_in);
        chk("phase", phase_out, CPPH_PH_ONE);
        chk("w", w_out, CPPH_W_RESET);
        chk("valid", exec_valid_out, 1'b0);
        port_pins_in[3] = 1'b1;
        repeat (2) @(negedge clk_in);
        chk("phase", phase_out, CPPH_PH_THREE);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Ends a hung run.
    initial begin
        repeat (2000) @(posedge clk_in);
        err_count++;
        results();
    end
    // Loads the program, resets, runs each scenario.
    initial begin
        static logic [13:0] prog [12] = '{14'h300F, 14'h3E01, 14'h00A0, 14'h3C10, 14'h30FF, 14'h3E02,
            14'h0820, 14'h2809, 14'h30AA, 14'h3C0F, 14'h3AF0, 14'h280B};
        rst_n_in = 1'b0;
        ext_reset_enable_in = 1'b0;
        quarter_rate_clock_out_enable_in = 1'b0;
        osc_mode_in = CPPH_FAST_CRYSTAL_MODE;
        pullup_select_in = 4'h0;
        change_irq_select_in = 4'h0;
        port_pin_two_timer_in = 1'b0;
        port_pin_two_irq_in = 1'b0;
        port_pins_in = 6'h08;
        for (int i = 0; i < 16; i++) mem.rom[i] = (i < 12) ? prog[i] : CPPH_NOP;
        repeat (12) @(negedge clk_in);
        rst_n_in = 1'b1;
        t_start();
        t_prog();
        t_pins();
        t_xreset();
        results();
    end
endmodule
`default_nettype wire
